// File: sim/usb_buffer_descriptor_engine_tb.sv
// Purpose: self-checking bench for the descriptor engine
// Assumes: zero wait state bus slave, host model plays the reports
// Notes: expected reads and handshakes are queued, a monitor pops them
`timescale 1ns/1ps
`default_nettype none
module usb_buffer_descriptor_engine_tb import bd_engine_pkg::*;;
	localparam logic [31:0] CFG = {20'h0, USB_CONFIG_ADDR};
	localparam logic [31:0] XS = {20'h0, TRANSFER_STATUS_ADDR};
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_pend;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, mode;
	logic [2:0] hsize;
	logic [3:0] tok_ep, ep;
	logic [7:0] v;
	logic tok_in, txn_valid, txn_ready, txn_done;
	bd_info_s tok_info;
	txn_s txn;
	hs_e txn_hs;
	logic par [16][2];
	logic [31:0] rd_q[$];
	hs_e hs_q[$];
	int fails, tests_run;
	int seed = 32'h09a147a4;
	assign hready = hreadyout;
	bd_engine bd_engine_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tok_ep(tok_ep), .tok_in(tok_in), .tok_info(tok_info),
		.txn_valid(txn_valid), .txn(txn), .txn_ready(txn_ready), .txn_done(txn_done), .txn_hs(txn_hs));
	usb_host_model usb_host_model_inst (.hclk(hclk), .txn_ready(txn_ready), .tok_ep(tok_ep), .tok_in(tok_in),
		.txn_valid(txn_valid), .txn(txn));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : compare
	always @(posedge hclk) begin
		if (rd_pend === 1'b1) compare(hrdata, rd_q.pop_front());
		if (txn_done === 1'b1) compare(32'(txn_hs), 32'(hs_q.pop_front()));
	end
	// read data is the value that the read expects; hwdata is scrambled then
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : ~d;
		rd_pend <= !w;
		if (!w) rd_q.push_back(d);
		do @(posedge hclk); while (hready !== 1'b1);
		rd_pend <= 1'b0;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b0, d);
	endtask : rd
	function automatic logic [31:0] da(input logic [5:0] n, input logic [1:0] k);
		return {22'h0, n, k, 2'b00};
	endfunction : da
	function automatic logic [5:0] exp_idx(input logic [1:0] m, input logic [3:0] e, input logic i, input logic o);
		case (m)
			2'h0: return {1'b0, e, i};
			2'h1: return (e == 4'h0 && !i) ? {5'h0, o} : {1'b0, e, 1'b0} + 6'(i) + 6'h1;
			2'h2: return {e, i, o};
			default: return (e == 4'h0) ? {5'h0, i} : {e, 2'b00} - 6'h2 + {4'h0, i, o};
		endcase
	endfunction : exp_idx
	task automatic check_idx(input logic [3:0] e, input logic i);
		usb_host_model_inst.token(e, i);
		compare(32'(tok_info.idx), 32'(exp_idx(mode, e, i, par[e][i])));
	endtask : check_idx
	// arms the descriptor the pointer selects, plays one report, reads back
	task automatic play(input logic [3:0] e, input logic [3:0] pid, input logic [7:0] st,
			input logic [9:0] lim, input logic [9:0] len, input logic d1, input hs_e h);
		logic i;
		logic upd;
		logic [5:0] n;
		i = (pid == PID_IN);
		n = exp_idx(mode, e, i, par[e][i]);
		upd = (h == HS_ACK) && !(st[3] && pid == PID_OUT && d1 != st[6]);
		wr(da(n, BYTE_COUNT), {24'h0, lim[7:0]});
		wr(da(n, BYTE_STATUS), {24'h0, st[7:2], lim[9:8]});
		usb_host_model_inst.token(e, i);
		compare(32'({tok_info.owned, tok_info.count}), 32'({st[7], lim}));
		hs_q.push_back(h);
		usb_host_model_inst.report('{e, pid, len, d1, 1'b0}, $random(seed) & 3);
		repeat (3) @(posedge hclk);
		if (upd) begin
			rd(da(n, BYTE_STATUS), {24'h0, 1'b0, st[6], pid, len[9:8]});
			rd(da(n, BYTE_COUNT), {24'h0, len[7:0]});
			rd(XS, {25'h0, e, i, par[e][i], 1'b0});
			par[e][i] = ~par[e][i];
		end else begin
			rd(da(n, BYTE_STATUS), {24'h0, st[7:2], lim[9:8]});
			rd(da(n, BYTE_COUNT), {24'h0, lim[7:0]});
		end
	endtask : play
	task automatic conclude();
		$display("counts tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		#500000;
		fails++;
		conclude();
	end
	initial begin
		{hresetn, hsel, hwrite, rd_pend, htrans, mode} = '0;
		haddr = '0;
		hwdata = '0;
		hsize = 3'h2;
		fails = 0;
		tests_run = 0;
		par = '{default: 1'b0};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(CFG, 32'h0);
		rd(XS, 32'h0);
		wr(32'h800, 32'hffffffff);
		rd(32'h800, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			v = 8'($random(seed));
			wr(da(6'(k * 21), 2'(2 + k % 2)), {24'h0, v});
			rd(da(6'(k * 21), 2'(2 + k % 2)), {24'h0, v});
		end
		$display("test address bytes done");
		for (int m = 0; m < 4; m++) begin
			mode = 2'(m);
			ep = 4'($random(seed)) | 4'h1;
			wr(CFG, {28'h0, 4'hc | 4'(m)});
			wr(CFG, {28'h0, 4'h8 | 4'(m)});
			par = '{default: 1'b0};
			for (int d = 0; d < 4; d++) check_idx(d[1] ? ep : 4'h0, d[0]);
			play(ep, PID_OUT, {1'b1, 7'($random(seed)) & 7'h40}, 10'h040, 10'h03f, 1'b0, HS_ACK);
			check_idx(ep, 1'b0);
			play(ep, PID_IN, 8'h80, 10'h020, 10'h020, 1'b1, HS_ACK);
			play(4'h0, PID_SETUP, 8'h80, 10'h008, 10'h008, 1'b0, HS_ACK);
			check_idx(4'h0, 1'b0);
		end
		$display("test buffering modes done");
		mode = 2'h2;
		wr(CFG, 32'he);
		wr(CFG, 32'ha);
		par = '{default: 1'b0};
		play(4'h3, PID_OUT, 8'h80, 10'h00a, 10'h00b, 1'b0, HS_NAK);
		play(4'h3, PID_OUT, 8'h80, 10'h00a, 10'h00a, 1'b0, HS_ACK);
		play(4'h3, PID_IN, 8'h84, 10'h010, 10'h010, 1'b0, HS_STALL);
		play(4'h3, PID_SETUP, 8'h84, 10'h008, 10'h008, 1'b0, HS_ACK);
		hs_q.push_back(HS_NAK);
		usb_host_model_inst.report('{4'h3, PID_OUT, 10'h001, 1'b0, 1'b1}, 0);
		play(4'h5, PID_OUT, 8'hc8, 10'h020, 10'h004, 1'b0, HS_ACK);
		play(4'h5, PID_OUT, 8'hc8, 10'h020, 10'h004, 1'b1, HS_ACK);
		play(4'h5, PID_OUT, 8'hc0, 10'h020, 10'h004, 1'b0, HS_ACK);
		play(4'h7, PID_IN, 8'h80, 10'h3ff, 10'h3ff, 1'b0, HS_ACK);
		play(4'h7, PID_IN, 8'h00, 10'h3ff, 10'h001, 1'b0, HS_NAK);
		$display("test limits and stalls done");
		check_idx(4'h7, 1'b1);
		wr(CFG, 32'he);
		wr(CFG, 32'ha);
		par = '{default: 1'b0};
		check_idx(4'h7, 1'b1);
		play(4'h7, PID_IN, 8'h80, 10'h004, 10'h004, 1'b0, HS_ACK);
		wr(CFG, 32'h2);
		par = '{default: 1'b0};
		play(4'h7, PID_IN, 8'h80, 10'h004, 10'h004, 1'b0, HS_NAK);
		wr(CFG, 32'ha);
		par = '{default: 1'b0};
		check_idx(4'h7, 1'b1);
		$display("test pointer reset done");
		conclude();
	end
endmodule : usb_buffer_descriptor_engine_tb
`default_nettype wire

// File: sim/usb_host_model.sv
// Purpose: host side model playing tokens and finished transaction reports
// Assumes: one report in flight, taken at an edge with txn_ready high
// Notes: report fields are inverted once taken so stale values never match
`timescale 1ns/1ps
`default_nettype none
module usb_host_model import bd_engine_pkg::*; (
	input wire logic hclk, // bus clock
	input wire logic txn_ready, // engine idle
	output logic [3:0] tok_ep, // token endpoint
	output logic tok_in, // token direction
	output logic txn_valid, // report strobe
	output txn_s txn // report body
);
	initial begin
		tok_ep = 4'h0;
		tok_in = 1'b0;
		txn_valid = 1'b0;
		txn = '0;
	end
	// lookup is registered, so the answer is settled one edge later; the task waits two edges
	task automatic token(input logic [3:0] e, input logic i);
		tok_ep <= e;
		tok_in <= i;
		repeat (2) @(posedge hclk);
	endtask : token
	// gap of idle cycles models a slow host; at least one edge between reports
	task automatic report(input txn_s t, input int gap);
		repeat (gap + 1) @(posedge hclk);
		txn <= t;
		txn_valid <= 1'b1;
		do @(posedge hclk); while (txn_ready !== 1'b1);
		txn_valid <= 1'b0;
		txn <= ~t;
	endtask : report
endmodule : usb_host_model
`default_nettype wire

// File: src/bd_engine.sv
// Purpose: descriptor table, ping-pong pointers and status write-back of a usb serial engine
// Assumes: serial engine reports finished transactions on txn_*; firmware uses AHB-Lite
// Notes: zero wait state slave, descriptor storage has no reset
//
// What this block does
// - owned descriptor gets token pid written into status bits 5:2
// - count low byte into count byte, bits 9:8 into status 1:0
// - IN sends descriptor count, then writes back bytes actually sent
// - OUT uses count as receive limit, writes back bytes received
// - OUT packet over the limit is NAKed, count left unchanged
// - byte count is ten bits, zero through 1023
// - buffer address is used as programmed, never checked
// - status bit 6 is never modified by write-back
// - after ownership, old toggle-check and stall bits are overwritten
// - expected toggle bit ignored unless toggle check enabled
// - two-bit field selects one of four buffering modes
// - per-endpoint pointers, all forced even while module is disabled
// - pointer toggles each time engine releases a descriptor while the pointer-reset bit is clear
// - parity of last transaction completed with the pointer-reset bit clear shown in transfer status
// - pointer-reset bit forces every pointer to even
// - no ping-pong: OUT uses 2n, IN uses 2n+1
// - ep0 OUT ping-pong: 0/1, ep0 IN 2, others 2n+1, 2n+2
// - all ping-pong: OUT 4n/4n+1, IN 4n+2/4n+3
// - all but ep0: ep0 0 and 1, others 4n-2.. 4n+1
// - table holds 64 descriptors of status, count, address low, high
// - descriptor bytes are not reset, unknown until written
// - ownership cleared when the transaction completes
`timescale 1ns/1ps
`default_nettype none
module bd_engine import bd_engine_pkg::*; #(
	parameter int HADDR_W = 32
) (
	input wire logic hclk, // bus clock, 40 MHz
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [HADDR_W-1:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	input wire logic [3:0] tok_ep, // endpoint of current token
	input wire logic tok_in, // current token is IN
	output bd_info_s tok_info, // descriptor the token would use
	input wire logic txn_valid, // finished transaction report
	input wire txn_s txn, // its details
	output logic txn_ready, // engine can take a report
	output logic txn_done, // answer pulse
	output hs_e txn_hs // handshake to return
);
	initial begin
		if (HADDR_W < 12)
			$error("bd_engine: HADDR_W must be at least 12");
	end

	// ----------------------------------------
	// storage and control state
	// ----------------------------------------
	logic [7:0] stat_mem [0:63];
	logic [7:0] cnt_mem [0:63];
	logic [7:0] adrl_mem [0:63];
	logic [7:0] adrh_mem [0:63];
	logic [3:0] usb_config_reg;
	logic [6:0] transfer_status_reg;
	logic [15:0] ptr_out;
	logic [15:0] ptr_in;
	eng_state_e state;
	txn_s txn_q;

	// ----------------------------------------
	// descriptor index mapping
	// ----------------------------------------
	function automatic logic [5:0] bd_index(input logic [1:0] mode, input logic [3:0] ep,
		input logic is_in, input logic odd);
		logic [7:0] n2;
		logic [7:0] n4;
		logic [7:0] r;
		n2 = {3'b000, ep, 1'b0};
		n4 = {2'b00, ep, 2'b00};
		r = 8'h00;
		case (mode)
			PP_NONE: r = n2 + {7'b0, is_in};
			PP_EP0_OUT: begin
				if (ep == 4'h0)
					r = is_in ? 8'h02 : {7'b0, odd};
				else
					r = n2 + 8'h01 + {7'b0, is_in};
			end
			PP_ALL: r = n4 + {6'b0, is_in, 1'b0} + {7'b0, odd};
			PP_NOT_EP0: begin
				if (ep == 4'h0)
					r = {7'b0, is_in};
				else
					r = n4 - 8'h02 + {6'b0, is_in, 1'b0} + {7'b0, odd};
			end
			default: r = 8'h00;
		endcase
		return r[5:0];
	endfunction : bd_index

	wire [1:0] pp_mode = usb_config_reg[CFG_MODE_LO +: 2];
	wire module_on = usb_config_reg[CFG_ENABLE];
	wire ptr_reset = usb_config_reg[CFG_PTR_RESET];

	// ----------------------------------------
	// token lookup for the transmitter
	// ----------------------------------------
	wire tok_odd = tok_in ? ptr_in[tok_ep] : ptr_out[tok_ep];
	wire [5:0] tok_idx = bd_index(pp_mode, tok_ep, tok_in, tok_odd);
	// address goes out untouched, whatever firmware put there
	wire bd_info_s next_tok_info = '{owned: stat_mem[tok_idx][STAT_OWN],
		count: {stat_mem[tok_idx][1:0], cnt_mem[tok_idx]},
		addr: {adrh_mem[tok_idx], adrl_mem[tok_idx]}, idx: tok_idx};

	// ----------------------------------------
	// transaction decision
	// ----------------------------------------
	wire q_in = (txn_q.pid == PID_IN);
	wire q_setup = (txn_q.pid == PID_SETUP);
	wire q_odd = q_in ? ptr_in[txn_q.ep] : ptr_out[txn_q.ep];
	wire [5:0] q_idx = bd_index(pp_mode, txn_q.ep, q_in, q_odd);
	wire [7:0] q_stat = stat_mem[q_idx];
	wire [9:0] q_limit = {q_stat[1:0], cnt_mem[q_idx]};
	wire q_owned = q_stat[STAT_OWN];
	wire q_stall = q_stat[STAT_STALL_EN] && !q_setup;
	wire q_over = !q_in && (txn_q.len > q_limit);
	// toggle compare only counts with checking on; setup always passes
	wire q_bad_toggle = !q_in && !q_setup && q_stat[STAT_TOGGLE_CHECK]
		&& (txn_q.data1 != q_stat[STAT_TOGGLE]);
	wire q_nak = !module_on || !q_owned || txn_q.err || q_over;
	wire deciding = (state == ST_DECIDE);
	wire commit = deciding && !q_nak && !q_stall && !q_bad_toggle;
	wire hs_e next_hs = q_nak ? HS_NAK : (q_stall ? HS_STALL : HS_ACK);
	// bit 6 kept, pid and count bits replace the old control bits
	wire [7:0] wb_stat = {1'b0, q_stat[STAT_TOGGLE], txn_q.pid, txn_q.len[9:8]};

	// ----------------------------------------
	// engine state machine
	// ----------------------------------------
	// ready gate: a report held across reset release is taken only once
	wire take = (state == ST_IDLE) && txn_ready && txn_valid;
	eng_state_e next_state;
	always_comb begin
		case (state)
			ST_IDLE: next_state = take ? ST_DECIDE : ST_IDLE;
			ST_DECIDE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			txn_q <= '0;
			txn_ready <= 1'b0;
			txn_done <= 1'b0;
			txn_hs <= HS_NAK;
			tok_info <= '0;
		end else begin
			state <= next_state;
			if (take)
				txn_q <= txn;
			txn_ready <= (next_state == ST_IDLE);
			txn_done <= deciding;
			if (deciding)
				txn_hs <= next_hs;
			tok_info <= next_tok_info;
		end
	end

	// ----------------------------------------
	// ping-pong pointers and transfer status
	// ----------------------------------------
	wire ptr_clear = !module_on || ptr_reset;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_out <= 16'h0000;
			ptr_in <= 16'h0000;
			transfer_status_reg <= XS_RESET_VALUE;
		end else if (ptr_clear) begin
			ptr_out <= 16'h0000;
			ptr_in <= 16'h0000;
		end else if (commit) begin
			if (q_in)
				ptr_in[txn_q.ep] <= !ptr_in[txn_q.ep];
			else
				ptr_out[txn_q.ep] <= !ptr_out[txn_q.ep];
			transfer_status_reg <= {txn_q.ep, q_in, q_odd, 1'b0};
		end
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	logic wr_pend;
	logic [11:0] wr_addr;
	wire addr_phase = hsel && htrans[1] && hready;
	wire [11:0] a_lo = haddr[11:0];
	wire desc_hit = (a_lo[11:10] == DESC_BASE[11:10]);
	wire [5:0] a_idx = a_lo[9:4];
	wire [1:0] a_byte = a_lo[3:2];
	wire w_desc = wr_pend && (wr_addr[11:10] == DESC_BASE[11:10]);
	wire [5:0] w_idx = wr_addr[9:4];
	wire [1:0] w_byte = wr_addr[3:2];
	wire fwd = wr_pend && (wr_addr[11:2] == a_lo[11:2]);

	logic [7:0] desc_rd;
	always_comb begin
		case (a_byte)
			BYTE_STATUS: desc_rd = stat_mem[a_idx];
			BYTE_COUNT: desc_rd = cnt_mem[a_idx];
			BYTE_ADDR_LOW: desc_rd = adrl_mem[a_idx];
			BYTE_ADDR_HIGH: desc_rd = adrh_mem[a_idx];
			default: desc_rd = 8'h00;
		endcase
	end

	// a read right behind a write to the same word sees the new data
	wire [31:0] rd_word = desc_hit ? {24'h0, fwd ? hwdata[7:0] : desc_rd}
		: (a_lo == USB_CONFIG_ADDR) ? {28'h0, fwd ? hwdata[3:0] : usb_config_reg}
		: (a_lo == TRANSFER_STATUS_ADDR) ? {25'h0, transfer_status_reg}
		: 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			usb_config_reg <= CFG_RESET_VALUE;
		end else begin
			wr_pend <= addr_phase && hwrite;
			if (addr_phase)
				wr_addr <= a_lo;
			if (addr_phase && !hwrite)
				hrdata <= rd_word;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (wr_pend && wr_addr == USB_CONFIG_ADDR)
				usb_config_reg <= hwdata[3:0];
		end
	end

	// no reset on the table; an engine write wins a clash on the status/count byte
	always_ff @(posedge hclk) begin
		if (w_desc && w_byte == BYTE_STATUS && !(commit && w_idx == q_idx))
			stat_mem[w_idx] <= hwdata[7:0];
		if (w_desc && w_byte == BYTE_COUNT && !(commit && w_idx == q_idx))
			cnt_mem[w_idx] <= hwdata[7:0];
		if (w_desc && w_byte == BYTE_ADDR_LOW)
			adrl_mem[w_idx] <= hwdata[7:0];
		if (w_desc && w_byte == BYTE_ADDR_HIGH)
			adrh_mem[w_idx] <= hwdata[7:0];
		if (commit) begin
			stat_mem[q_idx] <= wb_stat;
			cnt_mem[q_idx] <= txn_q.len[7:0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_taken;
		take;
	endsequence
	sequence s_ready_back;
		!txn_ready ##1 txn_ready;
	endsequence
	sequence s_commit;
		commit ##1 1'b1;
	endsequence

	chk_pid_writeback: assert property (s_commit |-> stat_mem[$past(q_idx)][5:2] == $past(txn_q.pid))
		else $error("pid not written into status");
	chk_count_split: assert property (s_commit |-> cnt_mem[$past(q_idx)] == $past(txn_q.len[7:0])
		&& stat_mem[$past(q_idx)][1:0] == $past(txn_q.len[9:8]))
		else $error("byte count not written back");
	chk_bit6_kept: assert property (commit |=> stat_mem[$past(q_idx)][6] == $past(q_stat[6]))
		else $error("status bit 6 modified");
	chk_over_nak: assert property (s_taken ##1 q_over |=> txn_done
		&& txn_hs == HS_NAK && cnt_mem[$past(q_idx)] == $past(cnt_mem[q_idx]))
		else $error("oversized packet not refused");
	chk_own_release: assert property (commit |=> !stat_mem[$past(q_idx)][STAT_OWN] && txn_done
		&& txn_hs == HS_ACK)
		else $error("ownership not released");
	chk_ptr_toggle: assert property (commit && !ptr_clear && !q_in |=> ptr_out[$past(txn_q.ep)]
		!= $past(ptr_out[txn_q.ep]))
		else $error("pointer did not toggle");
	chk_ptr_reset: assert property (ptr_clear |=> ptr_out == 16'h0000 && ptr_in == 16'h0000)
		else $error("pointers not forced even");
	chk_mode0_map: assert property (deciding && pp_mode == PP_NONE |-> q_idx == {txn_q.ep, q_in})
		else $error("mode 0 mapping wrong");
	chk_toggle_ignore: assert property (deciding && q_bad_toggle && !q_nak && !q_stall |=> txn_hs == HS_ACK
		&& stat_mem[$past(q_idx)] == $past(q_stat))
		else $error("bad toggle packet was stored");
	chk_parity_flag: assert property (commit && !ptr_clear |=> transfer_status_reg[XS_PARITY] == $past(q_odd))
		else $error("parity flag wrong");
	chk_answer_time: assert property (s_taken |-> ##2 txn_done ##1 !txn_done)
		else $error("answer not one pulse two edges after report");
	chk_ready_drop: assert property (s_taken |=> s_ready_back)
		else $error("engine ready not dropped for one cycle");

	// ----------------------------------------
	// checks: handshake decisions, refusals leave the descriptor alone
	// ----------------------------------------
	chk_nak_hold: assert property (deciding && q_nak |=> txn_done && txn_hs == HS_NAK
		&& stat_mem[$past(q_idx)] == $past(q_stat))
		else $error("refused transaction changed status");
	chk_stall_hold: assert property (deciding && !q_nak && q_stall |=> txn_hs == HS_STALL
		&& stat_mem[$past(q_idx)] == $past(q_stat))
		else $error("stalled transaction changed status");
	chk_setup_pass: assert property (deciding && q_setup && !q_nak |=> txn_hs == HS_ACK)
		else $error("setup not accepted");
	chk_disabled_nak: assert property (deciding && !module_on |=> txn_done && txn_hs == HS_NAK)
		else $error("disabled engine did not refuse");
	chk_count_limit: assert property (commit && !q_in |-> txn_q.len <= q_limit)
		else $error("stored packet beyond receive limit");

	// ----------------------------------------
	// checks: pointers and transfer status
	// ----------------------------------------
	chk_ptr_in_toggle: assert property (commit && !ptr_clear && q_in |=> ptr_in[$past(txn_q.ep)]
		!= $past(ptr_in[txn_q.ep]))
		else $error("in pointer did not toggle");
	// out and in pointers are separate; an out release must not drag the in pointers
	chk_ptr_apart: assert property (commit && !ptr_clear && !q_in |=> ptr_in == $past(ptr_in))
		else $error("out transaction moved an in pointer");
	chk_ptr_hold: assert property (!commit && !ptr_clear |=> ptr_out == $past(ptr_out)
		&& ptr_in == $past(ptr_in))
		else $error("pointer moved without a release");
	chk_status_ep: assert property (commit && !ptr_clear |=> transfer_status_reg[XS_EP_LO +: 4]
		== $past(txn_q.ep) && transfer_status_reg[XS_DIR_IN] == $past(q_in))
		else $error("transfer status endpoint wrong");

	// ----------------------------------------
	// checks: descriptor index mapping
	// ----------------------------------------
	chk_tok_index: assert property (1'b1 |=> tok_info.idx == $past(tok_idx))
		else $error("token lookup index late or wrong");
	chk_mode1_ep0: assert property (deciding && pp_mode == PP_EP0_OUT && txn_q.ep == 4'h0
		|-> q_idx == (q_in ? 6'h02 : {5'h00, q_odd}))
		else $error("mode 1 endpoint 0 mapping wrong");
	chk_mode1_map: assert property (deciding && pp_mode == PP_EP0_OUT && txn_q.ep != 4'h0
		|-> q_idx == {1'b0, txn_q.ep, 1'b0} + 6'h01 + 6'(q_in))
		else $error("mode 1 mapping wrong");
	chk_mode2_map: assert property (deciding && pp_mode == PP_ALL
		|-> q_idx == {txn_q.ep, q_in, q_odd})
		else $error("mode 2 mapping wrong");
	chk_mode3_ep0: assert property (deciding && pp_mode == PP_NOT_EP0 && txn_q.ep == 4'h0
		|-> q_idx == {5'h00, q_in})
		else $error("mode 3 endpoint 0 mapping wrong");
	chk_mode3_map: assert property (deciding && pp_mode == PP_NOT_EP0 && txn_q.ep != 4'h0
		|-> q_idx == {txn_q.ep, 2'b00} - 6'h02 + {4'h0, q_in, q_odd})
		else $error("mode 3 mapping wrong");

	// ----------------------------------------
	// checks: register bus
	// ----------------------------------------
	// unmapped reads must come back clean so firmware probing sees zero
	chk_unmapped_zero: assert property (addr_phase && !hwrite && !desc_hit && a_lo != USB_CONFIG_ADDR
		&& a_lo != TRANSFER_STATUS_ADDR |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
endmodule : bd_engine
`default_nettype wire

// File: src/bd_engine_pkg.sv
// Purpose: shared constants and types for the buffer descriptor engine
// Assumes: AHB-Lite word access, 64 descriptors of four bytes each
// Notes: descriptor byte k of descriptor n sits at byte address n*16 + k*4
package bd_engine_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] DESC_BASE = 12'h000;
	localparam logic [11:0] USB_CONFIG_ADDR = 12'h400;
	localparam logic [11:0] TRANSFER_STATUS_ADDR = 12'h404;
	localparam logic [1:0] BYTE_STATUS = 2'h0;
	localparam logic [1:0] BYTE_COUNT = 2'h1;
	localparam logic [1:0] BYTE_ADDR_LOW = 2'h2;
	localparam logic [1:0] BYTE_ADDR_HIGH = 2'h3;
	// ----------------------------------------
	// descriptor status fields
	// ----------------------------------------
	localparam int STAT_OWN = 7;
	localparam int STAT_TOGGLE = 6;
	localparam int STAT_PID_LO = 2;
	localparam int STAT_TOGGLE_CHECK = 3;
	localparam int STAT_STALL_EN = 2;
	// ----------------------------------------
	// usb_config_reg fields
	// ----------------------------------------
	localparam int CFG_MODE_LO = 0;
	localparam int CFG_PTR_RESET = 2;
	localparam int CFG_ENABLE = 3;
	localparam logic [3:0] CFG_RESET_VALUE = 4'h0;
	// ----------------------------------------
	// transfer_status_reg fields
	// ----------------------------------------
	localparam int XS_PARITY = 1;
	localparam int XS_DIR_IN = 2;
	localparam int XS_EP_LO = 3;
	localparam logic [6:0] XS_RESET_VALUE = 7'h00;
	// ----------------------------------------
	// token pids
	// ----------------------------------------
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;
	localparam logic [9:0] COUNT_MAX = 10'h3ff;

	typedef enum logic [1:0] {
		PP_NONE = 2'b00,
		PP_EP0_OUT = 2'b01,
		PP_ALL = 2'b10,
		PP_NOT_EP0 = 2'b11
	} pp_mode_e;

	typedef enum logic [1:0] {
		HS_ACK = 2'b00,
		HS_NAK = 2'b01,
		HS_STALL = 2'b10
	} hs_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DECIDE = 2'b01
	} eng_state_e;

	typedef struct packed {
		logic [3:0] ep;
		logic [3:0] pid;
		logic [9:0] len;
		logic data1;
		logic err;
	} txn_s;

	typedef struct packed {
		logic owned;
		logic [9:0] count;
		logic [15:0] addr;
		logic [5:0] idx;
	} bd_info_s;
endpackage : bd_engine_pkg
